//--- power_reset_clock_manager_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef POWER_RESET_CLOCK_MANAGER_CONSTS_SVH
`define POWER_RESET_CLOCK_MANAGER_CONSTS_SVH

`define OFS_POWER_MODE      16'h1000
`define OFS_PERIPH_CLOCK    16'h1008
`define OFS_MAP_STATE       16'h100C
`define OFS_MAP_CONTROL     16'h1010
`define OFS_SOFT_RESET      16'h1030
`define PERIPH_CLOCK_RESET  16'h0000
`define MAP_RESET           3'h0
`define SLEEP_ENTER         2'h3
`define SLEEP_CLEAR         2'h0
`define CAUSE_POWER_ON      2'h0
`define CAUSE_SOFT_UNIT     2'h1
`define CAUSE_SOFT_WDOG     2'h2
`define CAUSE_WDOG_OVF      2'h3
`define START_POWER_ON      2'h0
`define START_SLEEP         2'h3
`define HOLD_CYCLES         6'd32
`define BIT_WAKE_SEL        15
`define BIT_IRQ_CLK_SEL     14
`define SRAM_DEFAULT_BASE   32'h0803_0000
`define CS_SIZE_LARGE       32'h0100_0000
`define CS_SIZE_SMALL       32'h0010_0000

`endif

//--- power_reset_clock_manager_pkg.sv
// types shared by the power, reset and clock manager
package power_reset_clock_manager_pkg;
   typedef enum logic [3:0] {
      ST_RESET = 4'b0001,
      ST_RUN   = 4'b0010,
      ST_SLEEP = 4'b0100,
      ST_WAKE  = 4'b1000
   } pm_state_t;

   typedef struct packed {
      pm_state_t   state;
      logic [5:0]  holdCount;
      logic [1:0]  cause;
      logic [1:0]  startKind;
      logic [15:0] periphClock;
      logic [2:0]  mapCtrl;
      logic        softReq;
      logic        divToggle;
      logic        ack;
      logic [31:0] rdata;
   } pm_regs_t;
endpackage

//--- power_reset_clock_manager.sv
// power, reset and clock manager with its register slave
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "power_reset_clock_manager_consts.svh"

// How it works
// - system reset on power-on, watchdog overflow, watchdog request or soft write
// - after power-on release, hold system 32 cycles before running
// - power-on reset acts asynchronously; outputs disabled while it is active
// - soft reset resets every system-bus block for several cycles
// - power-down disables both buses; interrupt block may stay running
// - interrupt wake passes a transient wake state, then run automatically
// - field 11 enters power-down, 00 clears status, others ignored
// - power-down field resets to run encoding 00
// - control and status share 0x1000: writes control, reads status
// - status [5:4] records cause of most recent reset
// - status [1:0] reads 00 after power-on, 11 after power-down
// - wake select bit: 0 fast interrupt wakes, 1 normal interrupt wakes
// - interrupt block clock: 0 crystal clock, 1 bus clock
// - divider fields: 000 undivided, 001 halved, others reserved
// - serial gate field: 00 both on, 01 port1, 10 port0, 11 off
// - remap written at one address, read back at another
// - sizing bit: 16MB per chip select at 0, 1MB at 1
// - flash remap to zero only in modes 6 and 7
// - sram at default base, or at zero when relocate bit set
// - soft reset bit 0 starts reset and clears itself at end
// - watchdog manual request is carried out as a soft reset
module power_reset_clock_manager
   import power_reset_clock_manager_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic [15:0] address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   input  wire logic        watchdogOverflow,
   input  wire logic        watchdog_manual_reset_request,
   input  wire logic        fast_interrupt_n,
   input  wire logic        normal_interrupt_n,
   input  wire logic [2:0]  operatingMode,
   input  wire logic        crystal_clock,
   output logic            systemReset_n,
   output logic            outputDisable,
   output logic            systemBusClockEnable,
   output logic            peripheralBusClockEnable,
   output logic            irqBlockUseBusClock,
   output logic            irqBlockClockEnable,
   output logic            watchdogClockEnable,
   output logic            serialClockEnable0,
   output logic            serialClockEnable1,
   output logic            counterClockEnable,
   output logic            converterClockEnable,
   output logic [31:0]     chipSelectSize,
   output logic [31:0]     sramBase,
   output logic            flashAtZero
);

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rstSync1;
   logic rstSync2;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstSync1 <= 1'b0;
         rstSync2 <= 1'b0;
      end else begin
         rstSync1 <= 1'b1;
         rstSync2 <= rstSync1;
      end
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // 000 follows bus clock, 001 every other cycle, reserved codes stop it
   function automatic logic divEnable(input logic [2:0] code,
                                      input logic tog);
      case (code)
         3'h0:    divEnable = 1'b1;
         3'h1:    divEnable = tog;
         default: divEnable = 1'b0;
      endcase
   endfunction

   pm_regs_t r;
   pm_regs_t next_r;
   logic     wakeEvent;
   logic     isSleep;
   logic     isRun;
   logic     wrCtrl;

   assign wakeEvent = r.periphClock[`BIT_WAKE_SEL] ? !normal_interrupt_n
                                                   : !fast_interrupt_n;
   assign isSleep = (r.state == ST_SLEEP);
   assign isRun   = (r.state == ST_RUN);
   assign wrCtrl  = write && (address == `OFS_POWER_MODE);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.ack = 1'b0;
      next_r.divToggle = !r.divToggle;
      if (r.state == ST_RESET && r.holdCount != 6'd0) begin
         next_r.holdCount = r.holdCount - 6'd1;
      end
      case (r.state)
         ST_RESET: begin
            if (r.holdCount == 6'd1) begin
               next_r.state   = ST_RUN;
               next_r.softReq = 1'b0;
            end
         end
         ST_RUN: begin
            if (wrCtrl && !r.ack && writedata[1:0] == `SLEEP_ENTER) begin
               next_r.state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wakeEvent) begin
               next_r.state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            next_r.state     = ST_RUN;
            next_r.startKind = `START_SLEEP;
         end
         default: next_r.state = ST_RESET;
      endcase
      // register slave: one wait cycle, answer on the second
      if ((read || write) && !r.ack) begin
         next_r.ack = 1'b1;
         next_r.rdata = 32'h0000_0000;
         if (write) begin
            case (address)
               `OFS_POWER_MODE: begin
                  if (writedata[1:0] == `SLEEP_CLEAR) begin
                     next_r.startKind = `START_POWER_ON;
                     next_r.cause     = `CAUSE_POWER_ON;
                  end
               end
               `OFS_PERIPH_CLOCK: next_r.periphClock = writedata[15:0];
               `OFS_MAP_CONTROL:  next_r.mapCtrl = writedata[2:0];
               `OFS_SOFT_RESET: begin
                  if (writedata[0]) begin
                     next_r.softReq = 1'b1;
                  end
               end
               default: ;
            endcase
         end else begin
            case (address)
               `OFS_POWER_MODE: next_r.rdata = {26'h0, r.cause, 2'h0,
                                                r.startKind};
               `OFS_PERIPH_CLOCK: next_r.rdata = {16'h0, r.periphClock};
               `OFS_MAP_STATE: next_r.rdata = {29'h0, r.mapCtrl};
               default: next_r.rdata = 32'h0000_0000;
            endcase
         end
      end
      // reset causes, power-on is handled by the asynchronous path
      if (r.state != ST_RESET) begin
         if (watchdogOverflow) begin
            next_r.cause = `CAUSE_WDOG_OVF;
         end else if (watchdog_manual_reset_request) begin
            next_r.cause = `CAUSE_SOFT_WDOG;
         end else if (next_r.softReq && !r.softReq) begin
            next_r.cause = `CAUSE_SOFT_UNIT;
         end
         if (watchdogOverflow || watchdog_manual_reset_request
             || (next_r.softReq && !r.softReq)) begin
            next_r.state     = ST_RESET;
            next_r.holdCount = `HOLD_CYCLES;
            next_r.startKind = `START_POWER_ON;
         end
      end
   end

   // cause is not cleared by soft resets; they set the start record back to 00
   always_ff @(posedge ref_clk or negedge rstSync2) begin
      if (!rstSync2) begin
         r.state       <= ST_RESET;
         r.holdCount   <= `HOLD_CYCLES;
         r.cause       <= `CAUSE_POWER_ON;
         r.startKind   <= `START_POWER_ON;
         r.periphClock <= `PERIPH_CLOCK_RESET;
         r.mapCtrl     <= `MAP_RESET;
         r.softReq     <= 1'b0;
         r.divToggle   <= 1'b0;
         r.ack         <= 1'b0;
         r.rdata       <= 32'h0000_0000;
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign readdata    = r.rdata;
   assign waitrequest = !r.ack;
   assign systemReset_n = isRun;
   assign outputDisable = !rstSync2;
   assign systemBusClockEnable     = isRun;
   assign peripheralBusClockEnable = isRun;
   assign irqBlockUseBusClock = r.periphClock[`BIT_IRQ_CLK_SEL];
   // bus clock stops in power-down, crystal clock does not
   assign irqBlockClockEnable = !irqBlockUseBusClock || !isSleep;
   assign watchdogClockEnable = isRun
                              && divEnable(r.periphClock[13:11], r.divToggle);
   // gate field 01 keeps port 1 running and stops port 0, 10 the reverse
   assign serialClockEnable0 = isRun && !r.periphClock[9]
                             && divEnable(r.periphClock[8:6], r.divToggle);
   assign serialClockEnable1 = isRun && !r.periphClock[10]
                             && divEnable(r.periphClock[8:6], r.divToggle);
   assign counterClockEnable = isRun
                             && divEnable(r.periphClock[5:3], r.divToggle);
   assign converterClockEnable = isRun
                               && divEnable(r.periphClock[2:0], r.divToggle);
   assign chipSelectSize = r.mapCtrl[2] ? `CS_SIZE_SMALL
                                        : `CS_SIZE_LARGE;
   assign flashAtZero = r.mapCtrl[1] && (operatingMode == 3'h6
                                      || operatingMode == 3'h7);
   assign sramBase = r.mapCtrl[0] ? 32'h0000_0000
                                  : `SRAM_DEFAULT_BASE;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_por_hold: assert property (@(posedge ref_clk)
      $rose(rstSync2) |-> !systemReset_n [*8])
      else $error("system left reset too early after power-on");
   a_wake_pass: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (isSleep && wakeEvent) |=> (r.state == ST_WAKE) ##1 isRun)
      else $error("wake did not pass through wake state to run");
   a_sleep_enter: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (isRun && wrCtrl && !r.ack && writedata[1:0] == 2'h3 && !watchdogOverflow
       && !watchdog_manual_reset_request) |=> isSleep)
      else $error("power-down not entered");
   a_sleep_gate: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      isSleep |-> !systemBusClockEnable && !peripheralBusClockEnable)
      else $error("bus clocks running in power-down");
   a_wdog_cause: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (isRun && watchdogOverflow) |=> r.cause == 2'h3 && !systemReset_n)
      else $error("overflow cause not recorded");
   a_soft_hold: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (isRun && watchdog_manual_reset_request) |=> !systemReset_n [*8])
      else $error("soft reset too short");
   a_soft_len: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      $rose(r.softReq) |-> ##[30:34] !r.softReq)
      else $error("soft reset bit not self-cleared");
   a_remap_read: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (read && !r.ack && address == 16'h100C) |=> readdata[2:0] == r.mapCtrl)
      else $error("remap readback wrong");
   a_flash_mode: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (operatingMode < 3'h6) |-> !flashAtZero)
      else $error("flash remap outside modes 6 and 7");
   a_start_kind: assert property (@(posedge ref_clk) disable iff (!rstSync2)
      (r.state == ST_WAKE) |=> r.startKind == 2'h3)
      else $error("start after power-down not recorded");

   c_sleep_wake: cover property (@(posedge ref_clk) isSleep ##[1:50] isRun);
   c_soft_reg: cover property (@(posedge ref_clk) $rose(r.softReq));
   c_wdog_req: cover property (@(posedge ref_clk)
      isRun && watchdog_manual_reset_request);
   c_por_run: cover property (@(posedge ref_clk) $rose(systemReset_n));

endmodule
`default_nettype wire

//--- far_side_model.sv
// watchdog and interrupt controller stand-in facing the power manager
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
   input  wire logic ref_clk,
   output logic      watchdogOverflow,
   output logic      watchdog_manual_reset_request,
   output logic      fast_interrupt_n,
   output logic      normal_interrupt_n
);
   initial begin
      watchdogOverflow = 1'b0;
      watchdog_manual_reset_request = 1'b0;
      fast_interrupt_n = 1'b1;
      normal_interrupt_n = 1'b1;
   end

   // ----------------------------------------
   // watchdog reset requests
   // ----------------------------------------
   // two-cycle pulse, as the watchdog gives it
   task automatic wdog(input logic ovf, input logic man);
      @(posedge ref_clk);
      watchdogOverflow <= ovf;
      watchdog_manual_reset_request <= man;
      repeat (2) @(posedge ref_clk);
      watchdogOverflow <= 1'b0;
      watchdog_manual_reset_request <= 1'b0;
   endtask

   // ----------------------------------------
   // interrupt outputs
   // ----------------------------------------
   // level withdrawn after a few cycles, as a handler would clear it
   task automatic irq(input logic normal);
      @(posedge ref_clk);
      fast_interrupt_n <= normal;
      normal_interrupt_n <= !normal;
      repeat (4) @(posedge ref_clk);
      fast_interrupt_n <= 1'b1;
      normal_interrupt_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

//--- tb_power_reset_clock_manager.sv
// self-checking bench for the power, reset and clock manager
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_power_reset_clock_manager;
   logic        ref_clk, rst_b, read, write, crystal_clock;
   logic [15:0] address;
   logic [31:0] writedata, readdata, chipSelectSize, sramBase, q;
   logic [2:0]  operatingMode;
   logic        waitrequest, systemReset_n, outputDisable, flashAtZero;
   logic        systemBusClockEnable, peripheralBusClockEnable;
   logic        irqBlockUseBusClock, irqBlockClockEnable;
   logic        watchdogClockEnable, serialClockEnable0, serialClockEnable1;
   logic        counterClockEnable, converterClockEnable;
   logic        watchdogOverflow, watchdog_manual_reset_request;
   logic        fast_interrupt_n, normal_interrupt_n;
   int          n_mismatch = 0;
   int          n_tests = 0;
   wire [3:0]   divEn = {watchdogClockEnable, serialClockEnable0,
                         counterClockEnable, converterClockEnable};
   int          pos [4] = '{11, 6, 3, 0};
   int          expEn [3] = '{8, 4, 0};

   power_reset_clock_manager uut (.ref_clk, .rst_b, .address, .read, .write,
      .writedata, .readdata, .waitrequest, .watchdogOverflow,
      .watchdog_manual_reset_request, .fast_interrupt_n, .normal_interrupt_n,
      .operatingMode, .crystal_clock, .systemReset_n, .outputDisable,
      .systemBusClockEnable, .peripheralBusClockEnable, .irqBlockUseBusClock,
      .irqBlockClockEnable, .watchdogClockEnable, .serialClockEnable0,
      .serialClockEnable1, .counterClockEnable, .converterClockEnable,
      .chipSelectSize, .sramBase, .flashAtZero);
   far_side_model model (.ref_clk, .watchdogOverflow,
      .watchdog_manual_reset_request, .fast_interrupt_n, .normal_interrupt_n);

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // crystal runs free and unrelated to the bus clock
   always #41 crystal_clock = ~crystal_clock;

   // ----------------------------------------
   // bus and reset tasks
   // ----------------------------------------
   task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      for (i = 0; i < 50; i++) begin
         @(posedge ref_clk);
         if (waitrequest === 1'b0) break;
      end
      q = readdata;
      `CHK(i < 50, 1'b1)
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m);
      bus(1'b0, a, 32'h0);
      `CHK(q & m, e)
   endtask
   task automatic wait_run(output int n);
      n = 0;
      while (systemReset_n !== 1'b1 && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
   endtask
   task automatic por();
      int n;
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (4) @(posedge ref_clk);
      `CHK({outputDisable, waitrequest, systemReset_n}, 3'h6)
      rst_b <= 1'b1;
      wait_run(n);
      `CHK(n >= 32 && n <= 37, 1'b1)
   endtask
   task automatic sleep_wake(input logic [31:0] pclk, input logic normal);
      int n;
      bus(1'b1, 16'h1008, pclk);
      bus(1'b1, 16'h1000, 32'h1);
      bus(1'b1, 16'h1000, 32'h2);
      `CHK(systemBusClockEnable, 1'b1)
      bus(1'b1, 16'h1000, 32'h3);
      repeat (3) @(negedge ref_clk);
      `CHK({systemBusClockEnable, peripheralBusClockEnable}, 2'h0)
      `CHK(irqBlockClockEnable, !pclk[14])
      model.irq(!normal);
      repeat (8) @(negedge ref_clk);
      `CHK(systemBusClockEnable, 1'b0)
      model.irq(normal);
      wait_run(n);
      `CHK(n, 0)
      rd(16'h1000, 32'h3, '1);
      bus(1'b1, 16'h1000, 32'h0);
      rd(16'h1000, 32'h0, '1);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      int n;
      logic [31:0] c;
      rst_b = 1'b0; address = '0; read = 1'b0; write = 1'b0;
      writedata = '0; operatingMode = 3'h0; crystal_clock = 1'b0;
      por();
      rd(16'h1000, 32'h0, '1);
      rd(16'h1008, 32'h0, '1);
      rd(16'h100C, 32'h0, '1);
      rd(16'h1020, 32'h0, '1);
      $display("test reset values done");
      bus(1'b1, 16'h1008, 32'h4000);
      `CHK(irqBlockUseBusClock, 1'b1)
      rd(16'h1008, 32'h4000, '1);
      for (int k = 0; k < 4; k++) begin
         for (int v = 0; v < 3; v++) begin
            bus(1'b1, 16'h1008, 32'(v) << pos[k]);
            n = 0;
            repeat (8) begin
               @(negedge ref_clk);
               n += divEn[3 - k];
            end
            `CHK(n, expEn[v])
         end
      end
      for (int g = 0; g < 4; g++) begin
         bus(1'b1, 16'h1008, 32'(g) << 9);
         @(negedge ref_clk);
         `CHK({serialClockEnable1, serialClockEnable0}, ~2'(g))
      end
      $display("test clock control done");
      bus(1'b1, 16'h1010, 32'h5);
      rd(16'h100C, 32'h5, '1);
      `CHK({chipSelectSize, sramBase}, {32'h0010_0000, 32'h0})
      for (int m = 0; m < 8; m++) begin
         operatingMode <= 3'(m);
         bus(1'b1, 16'h1010, 32'h2);
         @(negedge ref_clk);
         `CHK(flashAtZero, m >= 6)
      end
      bus(1'b1, 16'h1010, 32'h0);
      rd(16'h100C, 32'h0, '1);
      `CHK({chipSelectSize, sramBase}, {32'h0100_0000, 32'h0803_0000})
      $display("test memory map done");
      sleep_wake(32'h0000, 1'b0);
      sleep_wake(32'hC000, 1'b1);
      $display("test power-down done");
      for (int k = 0; k < 4; k++) begin
         c = (k == 3) ? 32'h3 : 32'(k + 1);
         if (k == 0) bus(1'b1, 16'h1030, 32'h1);
         else model.wdog(k >= 2, k != 2);
         repeat (3) @(negedge ref_clk);
         `CHK(systemReset_n, 1'b0)
         wait_run(n);
         `CHK(n >= 27 && n <= 29, 1'b1)
         rd(16'h1000, c << 4, 32'h30);
      end
      $display("test soft resets done");
      por();
      rd(16'h1000, 32'h0, 32'h33);
      $display("test power-on again done");
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      complete_run();
   end
endmodule
`default_nettype wire
